// >>> logic/eil_pkg.sv
// Shared constants and types of the eight level interrupt unit
package eil_pkg;
  // Timing
  localparam int CLK_MHZ   = 100;
  localparam int MC_CLOCKS = 2;   // system clocks per machine cycle
  localparam int MAX_MC    = 4;   // longest instruction in machine cycles

  // Condition flag layout, bit 2 reserved and reads zero
  localparam int         FLAG_CARRY  = 3;
  localparam int         FLAG_BRANCH = 1;
  localparam int         FLAG_IE     = 0;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] FLAGS_MASK  = 4'hB;

  // Interrupt controller
  localparam int          LEVELS      = 8;
  localparam logic [7:0]  PEND_RESET  = 8'h00;
  localparam logic [7:0]  ACT_RESET   = 8'h00;
  localparam logic [11:0] VEC_BASE    = 12'h040;
  localparam logic [11:0] VEC_STEP    = 12'h040;
  localparam logic [11:0] VEC_TOP     = 12'h1E0;
  localparam logic [7:0]  IRQ_OPCODE [LEVELS] = '{8'hC8, 8'hD0, 8'hD8, 8'hE8, 8'hE8, 8'hF0, 8'hF8, 8'hFC};

  // Reset entry
  localparam logic [11:0] BOOT_ADDR   = 12'h008;
  localparam logic [7:0]  BOOT_OPCODE = 8'hC1;

  // Sources: pins p50,p51,p52,p53,p40,p43 and seven peripheral events
  localparam int IO_ADDRS = 16;
  localparam int NUM_PINS = 6;
  localparam int NUM_EVT  = 7;
  localparam int NUM_SRC  = 13;

  typedef enum logic [3:0] {
    CMD_NOP    = 4'h0,
    CMD_ALU    = 4'h1,
    CMD_SET_BC = 4'h2,
    CMD_TOG_B  = 4'h3,
    CMD_FSTORE = 4'h4,
    CMD_DI     = 4'h5,
    CMD_EI     = 4'h6,
    CMD_SLEEP  = 4'h7,
    CMD_IN     = 4'h8,
    CMD_OUT    = 4'h9,
    CMD_SWI    = 4'hA,
    CMD_RTI    = 4'hB,
    CMD_BRANCH = 4'hC
  } eil_cmd_e;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_AND = 3'h2,
    ALU_OR  = 3'h3,
    ALU_XOR = 3'h4,
    ALU_SHL = 3'h5,
    ALU_ROR = 3'h6
  } eil_alu_e;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b11,
    ST_ACK  = 2'b10
  } eil_state_e;
endpackage

// >>> logic/eil_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs
module eil_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;
endmodule

// >>> logic/eil_prio_enc.sv
// Highest set bit finder for eight level vectors
module eil_prio_enc (
  input  wire logic [7:0] vec,
  output logic            any,
  output logic      [2:0] idx
);
  // Scan upward so the highest level wins
  always_comb
  begin
    any = 1'b0;
    idx = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (vec[i])
      begin
        any = 1'b1;
        idx = 3'(i);
      end
    end
  end
endmodule

// >>> logic/eil_core.sv
// Interrupt unit with condition flags, ALU flag effects and instruction sequencing
module eil_core
  import eil_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [NUM_PINS-1:0] portPins,
  input  wire logic [NUM_EVT-1:0]  periphEvt,
  input  wire logic [NUM_SRC-1:0]  srcMask,
  input  wire logic             cmdValid,
  input  wire eil_pkg::eil_cmd_e cmdOp,
  input  wire eil_pkg::eil_alu_e aluOp,
  input  wire logic [1:0]       cmdCycles,
  input  wire logic [3:0]       topOfStack,
  input  wire logic [3:0]       secondOfStack,
  input  wire logic [3:0]       cmdIoAddr,
  input  wire logic [11:0]      cmdTarget,
  input  wire logic [11:0]      retPopData,
  input  wire logic [3:0]       ioRData,
  output logic                  cmdReady,
  output logic [3:0]            conditionFlags,
  output logic [7:0]            pendingLevels,
  output logic [7:0]            activeLevels,
  output logic [3:0]            tosOut,
  output logic                  tosWr,
  output logic                  ioRd,
  output logic                  ioWr,
  output logic [3:0]            ioAddr,
  output logic [3:0]            ioWData,
  output logic                  ioResetMode,
  output logic                  portsInput,
  output logic                  callValid,
  output logic [11:0]           callAddr,
  output logic [7:0]            callOpcode,
  output logic                  retPush,
  output logic [11:0]           retPushData,
  output logic                  retPop,
  output logic                  branchTaken,
  output logic                  fetchReq,
  output logic [11:0]           fetchAddr
);
  eil_state_e  state_ff, nxt_state;
  logic        phase_ff, nxt_phase;
  logic [1:0]  cycLeft_ff, nxt_cycLeft;
  logic        ioCycle_ff, nxt_ioCycle;
  logic [3:0]  flags_ff, nxt_flags;
  logic [7:0]  pend_ff, nxt_pend;
  logic [7:0]  act_ff, nxt_act;
  logic [7:0]  hold_ff, nxt_hold;
  logic [2:0]  ackLvl_ff, nxt_ackLvl;
  logic [11:0] pc_ff, nxt_pc;
  logic [3:0]  tos_ff, nxt_tos;
  logic        tosWr_ff, nxt_tosWr;
  logic        ioRd_ff, nxt_ioRd;
  logic        ioWr_ff, nxt_ioWr;
  logic [3:0]  ioAddr_ff, nxt_ioAddr;
  logic [3:0]  ioWData_ff, nxt_ioWData;
  logic        ioReset_ff;
  logic        callValid_ff, nxt_callValid;
  logic [11:0] callAddr_ff, nxt_callAddr;
  logic [7:0]  callOp_ff, nxt_callOp;
  logic        retPush_ff, nxt_retPush;
  logic [11:0] retData_ff, nxt_retData;
  logic        retPop_ff, nxt_retPop;
  logic        branch_ff, nxt_branch;
  logic        fetch_ff, nxt_fetch;
  logic [1:0]  arm_ff, nxt_arm;
  logic [NUM_PINS-1:0] pinSync;
  logic [NUM_PINS-1:0] pinLast_ff;
  logic [NUM_PINS-1:0] pinEdge;
  logic [NUM_SRC-1:0]  srcLive;
  logic [7:0]  levelReq;
  logic [7:0]  setPend;
  logic [7:0]  clrPend;
  logic        pendAny, actAny;
  logic [2:0]  pendIdx, actIdx;
  logic        mcEnd, irqSig, ackGo, take;
  logic [5:0]  aluRes;

  // Carry, branch and result of one ALU step
  function automatic logic [5:0] aluFn(input eil_alu_e op, input logic [3:0] a, input logic [3:0] b,
                                       input logic cin);
    logic [4:0] s;
    logic [3:0] r;
    s = 5'h00;
    r = 4'h0;
    unique case (op)
      ALU_ADD: s = {1'b0, b} + {1'b0, a};
      ALU_SUB: s = {1'b0, b} - {1'b0, a};
      ALU_AND: r = b & a;
      ALU_OR:  r = b | a;
      ALU_XOR: r = b ^ a;
      ALU_SHL: s = {a, cin};
      ALU_ROR: s = {a[0], cin, a[3:1]};
      default: r = a;
    endcase
    if (op == ALU_ADD || op == ALU_SUB || op == ALU_SHL || op == ALU_ROR)
      return {s[4], s[4], s[3:0]};
    return {cin, (r == 4'h0), r}; // Boolean ops keep carry
  endfunction

  function automatic logic [11:0] vecOf(input logic [2:0] lvl);
    if (lvl == 3'h7)
      return VEC_TOP;
    return VEC_BASE + VEC_STEP * {9'h000, lvl};
  endfunction

  // Pins are asynchronous, peripheral events share this clock
  eil_sync #(.W(NUM_PINS)) uPinSync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .asyncIn  (portPins),
    .syncOut  (pinSync)
  );

  // A pin held high through reset is a level, not an edge: wait until the synchroniser has filled
  assign pinEdge = (pinSync ^ pinLast_ff) & {NUM_PINS{arm_ff == 2'h3}};
  // Order: p52 p53 t1 ser p40 p43 t2 t3c1 t3c2 t3e p50 p51 vm
  assign srcLive = {periphEvt[6], pinEdge[1:0], periphEvt[5:2], pinEdge[5:4], periphEvt[1:0], pinEdge[3:2]}
                   & ~srcMask;
  // Level 0 is software only
  assign levelReq = {srcLive[12], |srcLive[11:10], |srcLive[9:7], srcLive[6], |srcLive[5:3], srcLive[2],
                     |srcLive[1:0], 1'b0};

  eil_prio_enc uPendEnc (
    .vec (pend_ff),
    .any (pendAny),
    .idx (pendIdx)
  );

  eil_prio_enc uActEnc (
    .vec (act_ff),
    .any (actAny),
    .idx (actIdx)
  );

  // Nesting only upward; equal or lower levels wait for return
  assign irqSig   = pendAny && (!actAny || pendIdx > actIdx);
  assign mcEnd    = phase_ff;
  assign ackGo    = (state_ff == ST_IDLE) && mcEnd && flags_ff[FLAG_IE] && irqSig;
  assign cmdReady = (state_ff == ST_IDLE) && mcEnd && !ackGo;
  assign take     = cmdReady && cmdValid;
  assign aluRes   = aluFn(aluOp, topOfStack, secondOfStack, flags_ff[FLAG_CARRY]);

  // Sequencing, flags and interrupt bookkeeping
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_phase     = ~phase_ff;
    nxt_cycLeft   = cycLeft_ff;
    nxt_ioCycle   = ioCycle_ff;
    nxt_flags     = flags_ff;
    nxt_act       = act_ff;
    nxt_ackLvl    = ackLvl_ff;
    nxt_pc        = pc_ff;
    nxt_tos       = tos_ff;
    nxt_tosWr     = 1'b0;
    nxt_ioRd      = 1'b0;
    nxt_ioWr      = 1'b0;
    nxt_ioAddr    = ioAddr_ff;
    nxt_ioWData   = ioWData_ff;
    nxt_callValid = 1'b0;
    nxt_callAddr  = callAddr_ff;
    nxt_callOp    = callOp_ff;
    nxt_retPush   = 1'b0;
    nxt_retData   = retData_ff;
    nxt_retPop    = 1'b0;
    nxt_branch    = 1'b0;
    nxt_fetch     = 1'b0;
    nxt_arm       = (arm_ff == 2'h3) ? arm_ff : arm_ff + 2'h1;
    clrPend       = 8'h00;
    // Requests wait in a hold latch through I/O cycles
    nxt_hold      = hold_ff | levelReq;
    setPend       = 8'h00;
    if (!ioCycle_ff)
    begin
      setPend  = nxt_hold;
      nxt_hold = 8'h00;
    end
    unique case (state_ff)
      ST_BOOT:
        if (mcEnd)
        begin
          nxt_callValid = 1'b1;
          nxt_callAddr  = BOOT_ADDR;
          nxt_callOp    = BOOT_OPCODE;
          nxt_pc        = BOOT_ADDR;
          nxt_state     = ST_IDLE;
        end
      ST_IDLE:
        if (ackGo)
        begin
          nxt_ackLvl  = pendIdx;
          nxt_act     = act_ff | (8'h01 << pendIdx);
          nxt_state   = ST_ACK;
          nxt_ioCycle = 1'b0;
        end
        else if (mcEnd)
        begin
          nxt_ioCycle = 1'b0;
          if (take)
          begin
            nxt_fetch = 1'b1;
            nxt_pc    = pc_ff + 12'h001;
            if (cmdCycles != 2'h0)
            begin
              nxt_state   = ST_EXEC;
              nxt_cycLeft = cmdCycles - 2'h1;
            end
            unique case (cmdOp)
              CMD_ALU:
              begin
                nxt_tos                = aluRes[3:0];
                nxt_tosWr              = 1'b1;
                nxt_flags[FLAG_CARRY]  = aluRes[5];
                nxt_flags[FLAG_BRANCH] = aluRes[4];
              end
              CMD_SET_BC:
              begin
                nxt_flags[FLAG_CARRY]  = 1'b1;
                nxt_flags[FLAG_BRANCH] = 1'b1;
              end
              CMD_TOG_B:  nxt_flags[FLAG_BRANCH] = ~flags_ff[FLAG_BRANCH];
              CMD_FSTORE: nxt_flags = topOfStack & FLAGS_MASK;
              CMD_DI:     nxt_flags[FLAG_IE] = 1'b0;
              CMD_EI:     nxt_flags[FLAG_IE] = 1'b1;
              CMD_SLEEP:  nxt_flags[FLAG_IE] = 1'b1;
              CMD_IN:
              begin
                nxt_ioRd    = 1'b1;
                nxt_ioAddr  = cmdIoAddr;
                nxt_ioCycle = 1'b1;
              end
              CMD_OUT:
              begin
                nxt_ioWr    = 1'b1;
                nxt_ioAddr  = cmdIoAddr;
                nxt_ioWData = topOfStack;
                nxt_ioCycle = 1'b1;
              end
              CMD_SWI:
              begin
                setPend     = setPend | {topOfStack, secondOfStack};
                nxt_ioCycle = 1'b1;
              end
              CMD_RTI:
              begin
                if (actAny)
                begin
                  clrPend = 8'h01 << actIdx;
                  nxt_act = act_ff & ~(8'h01 << actIdx);
                end
                nxt_pc     = retPopData;
                nxt_retPop = 1'b1;
              end
              CMD_BRANCH:
                if (flags_ff[FLAG_BRANCH])
                begin
                  nxt_pc     = cmdTarget;
                  nxt_branch = 1'b1;
                end
              default:
              begin
              end
            endcase
          end
        end
      ST_EXEC:
        if (mcEnd)
        begin
          if (cycLeft_ff == 2'h0)
          begin
            nxt_state   = ST_IDLE;
            nxt_ioCycle = 1'b0;
          end
          else
            nxt_cycLeft = cycLeft_ff - 2'h1;
        end
      ST_ACK:
        if (mcEnd)
        begin
          // Bank register is left to software
          nxt_callValid = 1'b1;
          nxt_callAddr  = vecOf(ackLvl_ff);
          nxt_callOp    = IRQ_OPCODE[ackLvl_ff];
          nxt_retPush   = 1'b1;
          nxt_retData   = pc_ff;
          nxt_pc        = vecOf(ackLvl_ff);
          nxt_state     = ST_IDLE;
        end
    endcase
    // Read data returns the clock after the strobe
    if (ioRd_ff)
    begin
      nxt_tos   = ioRData;
      nxt_tosWr = 1'b1;
    end
    // A new request beats a clear in the same clock
    nxt_pend = (pend_ff & ~clrPend) | setPend;
  end

  // Master reset cannot be masked by any program state
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff     <= ST_BOOT;
      phase_ff     <= 1'b0;
      cycLeft_ff   <= 2'h0;
      ioCycle_ff   <= 1'b0;
      flags_ff     <= FLAGS_RESET;
      pend_ff      <= PEND_RESET;
      act_ff       <= ACT_RESET;
      hold_ff      <= PEND_RESET;
      ackLvl_ff    <= 3'h0;
      pc_ff        <= 12'h000;
      tos_ff       <= 4'h0;
      tosWr_ff     <= 1'b0;
      ioRd_ff      <= 1'b0;
      ioWr_ff      <= 1'b0;
      ioAddr_ff    <= 4'h0;
      ioWData_ff   <= 4'h0;
      ioReset_ff   <= 1'b1;
      callValid_ff <= 1'b0;
      callAddr_ff  <= 12'h000;
      callOp_ff    <= 8'h00;
      retPush_ff   <= 1'b0;
      retData_ff   <= 12'h000;
      retPop_ff    <= 1'b0;
      branch_ff    <= 1'b0;
      fetch_ff     <= 1'b0;
      pinLast_ff   <= '0;
      arm_ff       <= 2'h0;
    end
    else
    begin
      state_ff     <= nxt_state;
      phase_ff     <= nxt_phase;
      cycLeft_ff   <= nxt_cycLeft;
      ioCycle_ff   <= nxt_ioCycle;
      flags_ff     <= nxt_flags;
      pend_ff      <= nxt_pend;
      act_ff       <= nxt_act;
      hold_ff      <= nxt_hold;
      ackLvl_ff    <= nxt_ackLvl;
      pc_ff        <= nxt_pc;
      tos_ff       <= nxt_tos;
      tosWr_ff     <= nxt_tosWr;
      ioRd_ff      <= nxt_ioRd;
      ioWr_ff      <= nxt_ioWr;
      ioAddr_ff    <= nxt_ioAddr;
      ioWData_ff   <= nxt_ioWData;
      ioReset_ff   <= 1'b0;
      callValid_ff <= nxt_callValid;
      callAddr_ff  <= nxt_callAddr;
      callOp_ff    <= nxt_callOp;
      retPush_ff   <= nxt_retPush;
      retData_ff   <= nxt_retData;
      retPop_ff    <= nxt_retPop;
      branch_ff    <= nxt_branch;
      fetch_ff     <= nxt_fetch;
      pinLast_ff   <= pinSync;
      arm_ff       <= nxt_arm;
    end
  end

  assign conditionFlags = flags_ff;
  assign pendingLevels  = pend_ff;
  assign activeLevels   = act_ff;
  assign tosOut         = tos_ff;
  assign tosWr          = tosWr_ff;
  assign ioRd           = ioRd_ff;
  assign ioWr           = ioWr_ff;
  assign ioAddr         = ioAddr_ff;
  assign ioWData        = ioWData_ff;
  assign ioResetMode    = ioReset_ff;
  assign portsInput     = ioReset_ff;
  assign callValid      = callValid_ff;
  assign callAddr       = callAddr_ff;
  assign callOpcode     = callOp_ff;
  assign retPush        = retPush_ff;
  assign retPushData    = retData_ff;
  assign retPop         = retPop_ff;
  assign branchTaken    = branch_ff;
  assign fetchReq       = fetch_ff;
  assign fetchAddr      = pc_ff;

  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  AST_TAKE_ON_MC_END: assert property (take |-> phase_ff ##1 !phase_ff)
    else $error("command taken off machine cycle end");
  AST_BOOT_CALL: assert property ((state_ff == ST_BOOT && mcEnd) |=>
    (callValid_ff && callAddr_ff == BOOT_ADDR && callOpcode == BOOT_OPCODE && state_ff == ST_IDLE))
    else $error("boot call wrong");
  AST_ACK_CALL: assert property (ackGo |=> ##2 (callValid_ff && retPush_ff && callAddr_ff == vecOf(ackLvl_ff)
    && retPushData == $past(pc_ff, 2)))
    else $error("acknowledge call wrong");
  AST_NO_ACK_DISABLED: assert property ((!flags_ff[FLAG_IE] && state_ff == ST_IDLE) |=> state_ff != ST_ACK)
    else $error("service started while disabled");
  AST_DI_CLEARS: assert property ((take && cmdOp == CMD_DI) |=> !flags_ff[FLAG_IE] [*2])
    else $error("disable did not clear enable");
  AST_PRIO: assert property (ackGo |=> (act_ff[ackLvl_ff] && (!$past(actAny) || ackLvl_ff > $past(actIdx))))
    else $error("acknowledged level not above active");
  AST_RTI_CLEAR: assert property ((take && cmdOp == CMD_RTI && actAny) |=>
    (!act_ff[$past(actIdx)] && pc_ff == $past(retPopData) && retPop_ff))
    else $error("return did not clear active level");
  AST_BOOL_CARRY: assert property ((take && cmdOp == CMD_ALU && aluOp == ALU_AND) |=>
    flags_ff[FLAG_CARRY] == $past(flags_ff[FLAG_CARRY]))
    else $error("boolean op changed carry");
  AST_REQ_LATCH: assert property ((!ioCycle_ff && levelReq[7]) |=> pend_ff[7])
    else $error("request not latched");
  AST_BRANCH_GATE: assert property ((take && cmdOp == CMD_BRANCH && !flags_ff[FLAG_BRANCH]) |=>
    !branchTaken && pc_ff == $past(pc_ff) + 12'h001)
    else $error("branch taken without flag");

  COV_ACK: cover property (callValid_ff && retPush_ff);
  COV_SWI: cover property (take && cmdOp == CMD_SWI);
  COV_NEST: cover property ($countones(act_ff) == 2);
endmodule

// >>> verif/eil_cpu_model.sv
// CPU side partner: return stack and I/O read responder
module eil_cpu_model (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        retPush,
  input  wire logic [11:0] retPushData,
  input  wire logic        retPop,
  input  wire logic        ioRd,
  input  wire logic [3:0]  ioAddr,
  output logic      [11:0] retPopData,
  output logic      [3:0]  ioRData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] retStack [8];
  logic [2:0]  retPtr;
  logic [3:0]  junk;

  // Return stack; junk steps by 5 each clock so stale read data matches on only one clock in sixteen
  always @(posedge core_clk or negedge rstn)
  begin
    junk <= rstn ? junk + 4'h5 : 4'h0;
    if (!rstn)
      retPtr <= 3'h0;
    else if (retPush)
    begin
      retStack[retPtr] <= retPushData;
      retPtr <= retPtr + 3'h1;
    end
    else if (retPop)
      retPtr <= retPtr - 3'h1;
  end

  // I/O read data is only meaningful while the strobe is up; pop data always shows the top entry
  assign retPopData = retStack[retPtr - 3'h1];
  assign ioRData    = ioRd ? ~ioAddr : junk;
endmodule

// >>> verif/eil_core_tb_top.sv
// Self-checking bench for the eight level interrupt unit
module eil_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eil_pkg::*;

  logic        core_clk, rstn, cmdValid, cmdReady, tosWr, ioRd, ioWr, ioResetMode, portsInput;
  logic        callValid, retPush, retPop, branchTaken, fetchReq;
  logic [5:0]  portPins;
  logic [6:0]  periphEvt;
  logic [12:0] srcMask;
  eil_cmd_e    cmdOp;
  eil_alu_e    aluOp;
  logic [1:0]  cmdCycles;
  logic [3:0]  topOfStack, secondOfStack, cmdIoAddr, ioRData, conditionFlags, tosOut, ioAddr, ioWData;
  logic [11:0] cmdTarget, retPopData, callAddr, retPushData, fetchAddr;
  logic [7:0]  pendingLevels, activeLevels, callOpcode;
  int          failures, checksDone, lastWait;

  eil_core i_dut (.core_clk, .rstn, .portPins, .periphEvt, .srcMask, .cmdValid, .cmdOp, .aluOp, .cmdCycles,
    .topOfStack, .secondOfStack, .cmdIoAddr, .cmdTarget, .retPopData, .ioRData, .cmdReady, .conditionFlags,
    .pendingLevels, .activeLevels, .tosOut, .tosWr, .ioRd, .ioWr, .ioAddr, .ioWData, .ioResetMode,
    .portsInput, .callValid, .callAddr, .callOpcode, .retPush, .retPushData, .retPop, .branchTaken,
    .fetchReq, .fetchAddr);
  eil_cpu_model i_cpu (.core_clk, .rstn, .retPush, .retPushData, .retPop, .ioRd, .ioAddr, .retPopData,
    .ioRData);

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic end_sim();
    if (failures == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Present a command at a falling edge and hold it until the edge that takes it
  task automatic issue(input eil_cmd_e op, input logic [3:0] t = 4'h0, input logic [3:0] s = 4'h0,
                       input eil_alu_e alu = ALU_ADD);
    int n;
    n = 0;
    @(negedge core_clk);
    cmdOp = op;
    aluOp = alu;
    topOfStack = t;
    secondOfStack = s;
    cmdValid = 1'b1;
    #1;
    while (cmdReady !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      #1;
      n++;
    end
    chk("cmdReady", 12'(cmdReady), 12'h001);
    @(negedge core_clk);
    cmdValid = 1'b0;
  endtask

  // Bounded wait for the vector call
  task automatic expect_call(input logic [11:0] addr, input logic [7:0] op, input logic push = 1'b1);
    lastWait = 0;
    while (callValid !== 1'b1 && lastWait < 12)
    begin
      @(negedge core_clk);
      lastWait++;
    end
    chk("callPush", 12'({callValid, retPush}), 12'({1'b1, push}));
    chk("callAddr", callAddr, addr);
    chk("callOpcode", 12'(callOpcode), 12'(op));
  endtask

  task automatic no_call(input int cyc);
    int seen;
    seen = 0;
    repeat (cyc)
    begin
      @(negedge core_clk);
      seen += int'(callValid === 1'b1);
    end
    chk("noCall", 12'(seen), 12'h000);
  endtask

  task automatic pulse_evt(input int i);
    @(negedge core_clk);
    periphEvt[i] = 1'b1;
    @(negedge core_clk);
    periphEvt[i] = 1'b0;
  endtask

  task automatic s_reset();
    @(negedge core_clk);
    rstn = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("clearRegs", 12'({conditionFlags, pendingLevels | activeLevels}), 12'h000);
    chk("ioReset", 12'({ioResetMode, portsInput}), 12'h003);
    rstn = 1'b1;
    expect_call(12'h008, 8'hC1, 1'b0);
    chk("ioReset", 12'({ioResetMode, portsInput}), 12'h000);
  endtask

  task automatic alu_case(input eil_alu_e op, input logic [3:0] t, s, r, f);
    issue(CMD_ALU, t, s, op);
    chk("aluTos", 12'({tosWr, tosOut}), 12'({1'b1, r}));
    chk("aluFlags", 12'(conditionFlags), 12'(f));
  endtask

  task automatic flag_cmd(input eil_cmd_e op, input logic [3:0] t, f, input logic br);
    issue(op, t);
    chk("flags", 12'(conditionFlags), 12'(f));
    chk("fetch", 12'(fetchReq), 12'h001);
    chk("branch", 12'(branchTaken), 12'(br));
  endtask

  // Carry kept by boolean ops, borrow on subtract, branch only on a set flag
  task automatic s_alu();
    alu_case(ALU_ADD, 4'h7, 4'h9, 4'h0, 4'hA);
    alu_case(ALU_OR, 4'h1, 4'h2, 4'h3, 4'h8);
    alu_case(ALU_AND, 4'hF, 4'h0, 4'h0, 4'hA);
    alu_case(ALU_SUB, 4'h5, 4'h3, 4'hE, 4'hA);
    alu_case(ALU_XOR, 4'h5, 4'h5, 4'h0, 4'hA);
    flag_cmd(CMD_BRANCH, 4'h0, 4'hA, 1'b1);
    chk("branchPc", fetchAddr, 12'h3A5);
    alu_case(ALU_SUB, 4'h3, 4'h5, 4'h2, 4'h0);
    flag_cmd(CMD_BRANCH, 4'h0, 4'h0, 1'b0);
    flag_cmd(CMD_SET_BC, 4'h0, 4'hA, 1'b0);
    flag_cmd(CMD_TOG_B, 4'h0, 4'h8, 1'b0);
    flag_cmd(CMD_FSTORE, 4'hE, 4'hA, 1'b0);
    flag_cmd(CMD_EI, 4'h0, 4'hB, 1'b0);
    flag_cmd(CMD_DI, 4'h0, 4'hA, 1'b0);
    // Four machine cycle op: refused until eight clocks after it was taken
    cmdCycles = 2'h3;
    issue(CMD_NOP);
    cmdCycles = 2'h0;
    lastWait = 0;
    while (cmdReady !== 1'b1 && lastWait < 20)
    begin
      @(negedge core_clk);
      lastWait++;
    end
    chk("execClocks", 12'(lastWait), 12'h007);
  endtask

  task automatic s_io();
    cmdIoAddr = 4'h5;
    issue(CMD_IN);
    chk("ioRead", 12'({ioRd, ioWr, ioAddr}), 12'h025);
    @(negedge core_clk);
    chk("inData", 12'({tosWr, tosOut}), 12'h01A);
    cmdIoAddr = 4'hC;
    issue(CMD_OUT, 4'h6);
    chk("ioWrite", 12'({ioRd, ioWr, ioAddr, ioWData}), 12'h1C6);
  endtask

  // Every source onto its level, a mid-run reset, then one source masked
  task automatic s_sources();
    int pinLvl[6] = '{6, 6, 1, 1, 3, 3};
    int evtLvl[7] = '{2, 3, 4, 5, 5, 5, 7};
    logic [7:0] exp;
    exp = 8'h00;
    for (int j = 0; j < 6; j++)
    begin
      @(negedge core_clk);
      portPins[j] = ~portPins[j];
      repeat (5) @(negedge core_clk);
      exp[pinLvl[j]] = 1'b1;
      chk("pinPend", 12'(pendingLevels), 12'(exp));
    end
    for (int i = 0; i < 7; i++)
    begin
      pulse_evt(i);
      @(negedge core_clk);
      exp[evtLvl[i]] = 1'b1;
      chk("evtPend", 12'(pendingLevels), 12'(exp));
    end
    s_reset();
    srcMask = 13'h1000;
    pulse_evt(6);
    pulse_evt(0);
    repeat (2) @(negedge core_clk);
    chk("masked", 12'(pendingLevels), 12'h004);
    srcMask = 13'h0000;
    s_reset();
  endtask

  // Each level raised by software while disabled, then served and returned
  task automatic s_levels();
    logic [7:0]  opc[8] = '{8'hC8, 8'hD0, 8'hD8, 8'hE8, 8'hE8, 8'hF0, 8'hF8, 8'hFC};
    logic [11:0] saved;
    for (int l = 0; l < 8; l++)
    begin
      issue(CMD_DI);
      issue(CMD_SWI, 4'((8'h01 << l) >> 4), 4'(8'h01 << l));
      no_call(10);
      chk("swiPend", 12'(pendingLevels), 12'(8'h01 << l));
      issue(CMD_EI);
      expect_call((l < 7) ? 12'(12'h040 * (l + 1)) : 12'h1E0, opc[l]);
      saved = retPushData;
      @(negedge core_clk);
      chk("active", 12'(activeLevels), 12'(8'h01 << l));
      issue(CMD_RTI);
      chk("rtiClear", 12'({retPop, pendingLevels | activeLevels}), 12'h100);
      chk("pcBack", fetchAddr, saved);
    end
  endtask

  // Higher level pre-empts, lower one waits for both returns
  task automatic s_nesting();
    issue(CMD_DI);
    issue(CMD_SWI, 4'h0, 4'h8);
    issue(CMD_EI);
    expect_call(12'h100, 8'hE8);
    pulse_evt(6);
    expect_call(12'h1E0, 8'hFC);
    chk("latency", 12'(lastWait < 10), 12'h001);
    issue(CMD_SWI, 4'h0, 4'h2);
    no_call(10);
    issue(CMD_RTI);
    issue(CMD_RTI);
    expect_call(12'h080, 8'hD0);
  endtask

  // Main sequence
  initial
  begin
    rstn = 1'b0;
    cmdValid = 1'b0;
    cmdOp = CMD_NOP;
    aluOp = ALU_ADD;
    cmdCycles = 2'h0;
    topOfStack = 4'h0;
    secondOfStack = 4'h0;
    cmdIoAddr = 4'h0;
    cmdTarget = 12'h3A5;
    portPins = 6'h00;
    periphEvt = 7'h00;
    srcMask = 13'h0000;
    s_reset();
    s_alu();
    s_io();
    s_sources();
    s_levels();
    s_nesting();
    end_sim();
  end

  // Watchdog, well beyond the few hundred clocks the sequence needs
  initial
  begin
    #100000;
    failures++;
    end_sim();
  end
endmodule
